// ==== src/amrmc_ctrl.sv ====
// mode, output data rate and motion feature control registers with bus-stall watchdogs
`timescale 1ns/1ps
`include "amrmc_defines.svh"

module amrmc_ctrl
   import amrmc_pkg::*;
#(
   parameter int CLK_HZ = `AMRMC_CLK_HZ,
   parameter int WDT_CYCLES = `AMRMC_WDT_TIMEOUT_US * (`AMRMC_CLK_HZ / 1000000)
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic scl_pin,
   input wire logic bus_busy,
   output logic wdt_timeout,
   output logic [1:0] op_state,
   output logic osc_run,
   output logic [2:0] osc_rate_sel,
   output logic sample_tick,
   output logic tilt_flip_enable,
   output logic motion_latch_enable,
   output logic any_motion_enable,
   output logic shake_enable,
   output logic tilt35_enable,
   output logic z_sign_select,
   output logic raw_flag_select,
   output logic motion_block_reset
);

   // refuse settings that would overflow the rate divider or the watchdog counter
   if (CLK_HZ / `AMRMC_ODR_HZ_0 > (1 << `AMRMC_DIV_W) || CLK_HZ < 2 * `AMRMC_ODR_HZ_7) begin : g_bad_clk
      $error("amrmc_ctrl: CLK_HZ outside what the rate divider can serve");
   end
   if (WDT_CYCLES < 2 || WDT_CYCLES >= (1 << `AMRMC_WDT_W)) begin : g_bad_wdt
      $error("amrmc_ctrl: WDT_CYCLES outside what the watchdog counter can serve");
   end

   localparam logic [`AMRMC_WDT_W-1:0] WDT_LAST = `AMRMC_WDT_W'(WDT_CYCLES - 1);

   amrmc_state_t s;
   amrmc_state_t next_s;

   // cycles between samples minus one for a rate code
   function automatic logic [`AMRMC_DIV_W-1:0] rate_div(input logic [2:0] code);
      int hz;
      hz = `AMRMC_ODR_HZ_0;
      unique case (code)
         3'h0: hz = `AMRMC_ODR_HZ_0;
         3'h1: hz = `AMRMC_ODR_HZ_1;
         3'h2: hz = `AMRMC_ODR_HZ_2;
         3'h3: hz = `AMRMC_ODR_HZ_3;
         3'h4: hz = `AMRMC_ODR_HZ_4;
         3'h5: hz = `AMRMC_ODR_HZ_5;
         3'h6: hz = `AMRMC_ODR_HZ_6;
         3'h7: hz = `AMRMC_ODR_HZ_7;
      endcase
      return `AMRMC_DIV_W'(CLK_HZ / hz - 1);
   endfunction

   logic wr_mode;
   logic wr_rate;
   logic wr_motion;
   logic rd_status;
   assign wr_mode = reg_wr && reg_addr == `AMRMC_ADDR_MODE;
   assign wr_rate = reg_wr && reg_addr == `AMRMC_ADDR_RATE;
   assign wr_motion = reg_wr && reg_addr == `AMRMC_ADDR_MOTION;
   assign rd_status = reg_rd && reg_addr == `AMRMC_ADDR_STATUS;

   always_comb begin
      logic stall;
      logic [7:0] mot;
      logic [`AMRMC_DIV_W-1:0] div_last;
      stall = 1'b0;
      mot = s.motion;
      div_last = '0;
      next_s = s;
      next_s.wdt_timeout = 1'b0;
      next_s.sample_tick = 1'b0;
      next_s.rvalid = 1'b0;

      // pin sampler: the level moves only when the two later stages agree
      next_s.scl_sync = {s.scl_sync[1:0], scl_pin};
      if (s.scl_sync[2] == s.scl_sync[1]) begin
         next_s.scl_level = s.scl_sync[2];
      end

      // register writes are taken in every operating state
      if (wr_mode) begin
         next_s.mode = {2'h0, reg_wdata[5:4], 2'h0, reg_wdata[1:0]};
         unique case (reg_wdata[1:0])
            2'b00: next_s.op = AMRMC_SLEEP;
            2'b01: next_s.op = AMRMC_WAKE;
            2'b11: next_s.op = AMRMC_STANDBY;
            default: next_s.op = s.op;
         endcase
      end
      if (wr_rate) begin
         next_s.rate = reg_wdata;
      end
      if (wr_motion) begin
         next_s.motion = reg_wdata;
         mot = reg_wdata;
      end
      next_s.shake_en = mot[`AMRMC_MOT_SHAKE] & mot[`AMRMC_MOT_ANY_MOTION];
      next_s.tilt35_en = mot[`AMRMC_MOT_TILT35] & mot[`AMRMC_MOT_ANY_MOTION];
      next_s.osc_run = next_s.op != AMRMC_SLEEP;

      // sample divider runs only in wake; a rate change restarts a count past the new end
      div_last = rate_div(s.rate[2:0]);
      if (s.op != AMRMC_WAKE) begin
         next_s.div_cnt = '0;
      end else if (s.div_cnt >= div_last) begin
         next_s.div_cnt = '0;
         next_s.sample_tick = 1'b1;
      end else begin
         next_s.div_cnt = s.div_cnt + 1'b1;
      end

      // watchdog counts a serial clock held at one level while a transfer is open
      stall = bus_busy && s.op != AMRMC_SLEEP &&
              ((s.mode[`AMRMC_MODE_LOW_WDT_BIT] && !s.scl_level) ||
               (s.mode[`AMRMC_MODE_HIGH_WDT_BIT] && s.scl_level));
      if (!stall || next_s.scl_level != s.scl_level) begin
         next_s.wdt_cnt = '0;
      end else if (s.wdt_cnt == WDT_LAST) begin
         next_s.wdt_cnt = '0;
         next_s.wdt_timeout = 1'b1;
      end else begin
         next_s.wdt_cnt = s.wdt_cnt + 1'b1;
      end

      // status read clears the watchdog flag, but a new timeout wins
      if (rd_status) begin
         next_s.wdt_flag = 1'b0;
      end
      if (next_s.wdt_timeout) begin
         next_s.wdt_flag = 1'b1;
      end

      if (reg_rd) begin
         next_s.rvalid = 1'b1;
         unique case (reg_addr)
            `AMRMC_ADDR_STATUS: next_s.rdata = {3'h0, s.wdt_flag, 2'h0, s.op};
            `AMRMC_ADDR_MODE: next_s.rdata = s.mode;
            `AMRMC_ADDR_RATE: next_s.rdata = s.rate;
            `AMRMC_ADDR_MOTION: next_s.rdata = s.motion;
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '{scl_sync: 3'h7, scl_level: 1'b1, wdt_cnt: '0, wdt_timeout: 1'b0, wdt_flag: 1'b0,
                mode: `AMRMC_MODE_RESET, op: AMRMC_SLEEP, rate: `AMRMC_RATE_RESET,
                motion: `AMRMC_MOTION_RESET, shake_en: 1'b0, tilt35_en: 1'b0, osc_run: 1'b0,
                div_cnt: '0, sample_tick: 1'b0, rdata: 8'h00, rvalid: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign reg_rvalid = s.rvalid;
   assign wdt_timeout = s.wdt_timeout;
   assign op_state = s.op;
   assign osc_run = s.osc_run;
   assign osc_rate_sel = s.rate[2:0];
   assign sample_tick = s.sample_tick;
   assign tilt_flip_enable = s.motion[`AMRMC_MOT_TILT_FLIP];
   assign motion_latch_enable = s.motion[`AMRMC_MOT_LATCH];
   assign any_motion_enable = s.motion[`AMRMC_MOT_ANY_MOTION];
   assign shake_enable = s.shake_en;
   assign tilt35_enable = s.tilt35_en;
   assign z_sign_select = s.motion[`AMRMC_MOT_Z_SIGN];
   assign raw_flag_select = s.motion[`AMRMC_MOT_RAW_FLAG];
   assign motion_block_reset = s.motion[`AMRMC_MOT_BLOCK_RESET];

   property p_no_tick_unless_wake;
      @(posedge core_clk) disable iff (!rst_n) sample_tick |-> $past(op_state) == AMRMC_WAKE;
   endproperty
   a_no_tick_unless_wake: assert property (p_no_tick_unless_wake)
      else $error("sample tick outside wake");

   property p_sleep_stops_osc;
      @(posedge core_clk) disable iff (!rst_n) wr_mode && reg_wdata[1:0] == 2'b00 |=> !osc_run ##1 !sample_tick;
   endproperty
   a_sleep_stops_osc: assert property (p_sleep_stops_osc)
      else $error("sleep write left oscillator or sampling running");

   property p_wake_ticks;
      @(posedge core_clk) disable iff (!rst_n) sample_tick |=> !sample_tick;
   endproperty
   a_wake_ticks: assert property (p_wake_ticks)
      else $error("sample ticks back to back");

   property p_standby;
      @(posedge core_clk) disable iff (!rst_n)
         wr_mode && reg_wdata[1:0] == 2'b11 |=> osc_run && op_state == AMRMC_STANDBY ##1 !sample_tick;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby write not obeyed");

   property p_reserved_keeps;
      @(posedge core_clk) disable iff (!rst_n) wr_mode && reg_wdata[1:0] == 2'b10 |=> $stable(op_state);
   endproperty
   a_reserved_keeps: assert property (p_reserved_keeps)
      else $error("reserved state code changed the operating state");

   property p_wdt_enabled;
      @(posedge core_clk) disable iff (!rst_n)
         wdt_timeout |-> $past(s.mode[`AMRMC_MODE_LOW_WDT_BIT] && !s.scl_level ||
                               s.mode[`AMRMC_MODE_HIGH_WDT_BIT] && s.scl_level);
   endproperty
   a_wdt_enabled: assert property (p_wdt_enabled)
      else $error("watchdog fired for a disabled stall level");

   property p_shake_needs_any;
      @(posedge core_clk) disable iff (!rst_n) (shake_enable || tilt35_enable) |-> any_motion_enable;
   endproperty
   a_shake_needs_any: assert property (p_shake_needs_any)
      else $error("shake or tilt-35 active without any-motion");

   property p_motion_follows;
      @(posedge core_clk) disable iff (!rst_n) wr_motion |=>
         {motion_block_reset, raw_flag_select, z_sign_select, motion_latch_enable, tilt_flip_enable} ==
         {$past(reg_wdata[7:5]), $past(reg_wdata[1]), $past(reg_wdata[0])};
   endproperty
   a_motion_follows: assert property (p_motion_follows)
      else $error("motion control outputs do not follow the write");

   property p_block_reset_holds;
      @(posedge core_clk) disable iff (!rst_n) motion_block_reset && !wr_motion |=> motion_block_reset;
   endproperty
   a_block_reset_holds: assert property (p_block_reset_holds)
      else $error("motion block reset cleared itself");

   property p_status_state;
      @(posedge core_clk) disable iff (!rst_n) rd_status |=> reg_rvalid && reg_rdata[1:0] == $past(op_state);
   endproperty
   a_status_state: assert property (p_status_state)
      else $error("status read did not report the operating state");

   property p_rate_sel;
      @(posedge core_clk) disable iff (!rst_n) wr_rate |=> osc_rate_sel == $past(reg_wdata[2:0]);
   endproperty
   a_rate_sel: assert property (p_rate_sel)
      else $error("oscillator rate select does not follow the rate write");

   property p_sleep_osc_off;
      @(posedge core_clk) disable iff (!rst_n) op_state == AMRMC_SLEEP |-> !osc_run;
   endproperty
   a_sleep_osc_off: assert property (p_sleep_osc_off)
      else $error("oscillator running in sleep");

   property p_awake_osc_on;
      @(posedge core_clk) disable iff (!rst_n) op_state != AMRMC_SLEEP |-> osc_run;
   endproperty
   a_awake_osc_on: assert property (p_awake_osc_on)
      else $error("oscillator stopped in wake or standby");

   property p_state_legal;
      @(posedge core_clk) disable iff (!rst_n) op_state != 2'h2;
   endproperty
   a_state_legal: assert property (p_state_legal)
      else $error("operating state took the reserved code");

   property p_wdt_needs_busy;
      @(posedge core_clk) disable iff (!rst_n) wdt_timeout |-> $past(bus_busy) && $past(op_state) != AMRMC_SLEEP;
   endproperty
   a_wdt_needs_busy: assert property (p_wdt_needs_busy)
      else $error("watchdog fired outside an open transfer or in sleep");

   property p_tick_restarts;
      @(posedge core_clk) disable iff (!rst_n) sample_tick |-> s.div_cnt == '0;
   endproperty
   a_tick_restarts: assert property (p_tick_restarts)
      else $error("sample divider did not restart on a tick");

endmodule

// ==== src/amrmc_defines.svh ====
// register offsets, field positions, reset values and timing figures of the mode/rate/motion bank
`ifndef AMRMC_DEFINES_SVH
`define AMRMC_DEFINES_SVH

`define AMRMC_ADDR_STATUS 8'h05
`define AMRMC_ADDR_MODE 8'h07
`define AMRMC_ADDR_RATE 8'h08
`define AMRMC_ADDR_MOTION 8'h09

`define AMRMC_MODE_RESET 8'h00
`define AMRMC_RATE_RESET 8'h00
`define AMRMC_MOTION_RESET 8'h00

`define AMRMC_MODE_LOW_WDT_BIT 4
`define AMRMC_MODE_HIGH_WDT_BIT 5
`define AMRMC_STATUS_WDT_BIT 4

`define AMRMC_MOT_TILT_FLIP 0
`define AMRMC_MOT_LATCH 1
`define AMRMC_MOT_ANY_MOTION 2
`define AMRMC_MOT_SHAKE 3
`define AMRMC_MOT_TILT35 4
`define AMRMC_MOT_Z_SIGN 5
`define AMRMC_MOT_RAW_FLAG 6
`define AMRMC_MOT_BLOCK_RESET 7

`define AMRMC_ODR_HZ_0 50
`define AMRMC_ODR_HZ_1 100
`define AMRMC_ODR_HZ_2 125
`define AMRMC_ODR_HZ_3 200
`define AMRMC_ODR_HZ_4 250
`define AMRMC_ODR_HZ_5 500
`define AMRMC_ODR_HZ_6 1000
`define AMRMC_ODR_HZ_7 2000

`define AMRMC_CLK_HZ 100000000
`define AMRMC_WDT_TIMEOUT_US 100
`define AMRMC_DIV_W 24
`define AMRMC_WDT_W 20

`endif

// ==== src/amrmc_pkg.sv ====
// types of the mode/rate/motion control bank
`include "amrmc_defines.svh"

package amrmc_pkg;

   typedef enum logic [1:0] {
      AMRMC_SLEEP = 2'b00,
      AMRMC_WAKE = 2'b01,
      AMRMC_STANDBY = 2'b11
   } amrmc_op_t;

   typedef struct packed {
      logic [2:0] scl_sync;
      logic scl_level;
      logic [`AMRMC_WDT_W-1:0] wdt_cnt;
      logic wdt_timeout;
      logic wdt_flag;
      logic [7:0] mode;
      amrmc_op_t op;
      logic [7:0] rate;
      logic [7:0] motion;
      logic shake_en;
      logic tilt35_en;
      logic osc_run;
      logic [`AMRMC_DIV_W-1:0] div_cnt;
      logic sample_tick;
      logic [7:0] rdata;
      logic rvalid;
   } amrmc_state_t;

endpackage

// ==== test/amrmc_host.sv ====
// host side model: serial engine register strobes, serial clock pin and transfer flag
`timescale 1ns/1ps
module amrmc_host (
   input wire logic core_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic scl_pin,
   output logic bus_busy
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      scl_pin = 1'b1;
      bus_busy = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h07) v = d & 8'h3b;
      if (a == 8'h08) v = {4'h0, 1'b1, d[2:0]};
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask

   // pull-up keeps the clock line high outside transfers; toggles are off the core clock phase
   task automatic link(input int toggles, input logic lvl, input int hold);
      @(posedge core_clk);
      bus_busy <= 1'b1;
      #3;
      // last phase takes the stall level, so the pin is assigned once per step
      repeat (toggles - 1) #80 scl_pin <= ~scl_pin;
      #80 scl_pin <= lvl;
      repeat (hold) @(posedge core_clk);
      @(posedge core_clk);
      bus_busy <= 1'b0;
      scl_pin <= 1'b1;
   endtask
endmodule

// ==== test/accel_mode_rate_motion_ctrl_bench.sv ====
// self-checking bench of the mode, rate and motion control bank
`timescale 1ns/1ps
module accel_mode_rate_motion_ctrl_bench;
   import amrmc_pkg::*;
   localparam int CLK_HZ = 200000;
   localparam int WDT = 16;
   logic core_clk;
   logic rst_n;
   logic reg_wr, reg_rd, reg_rvalid, scl_pin, bus_busy, wdt_timeout, osc_run, sample_tick;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v, mot;
   logic [1:0] op_state;
   logic [2:0] osc_rate_sel;
   logic tilt_flip_enable, motion_latch_enable, any_motion_enable, shake_enable, tilt35_enable;
   logic z_sign_select, raw_flag_select, motion_block_reset;
   int bad_count = 0;
   int checks_done = 0;
   int wdt_seen = 0;
   int tick_seen = 0;
   int output_sample_rate[8] = '{50, 100, 125, 200, 250, 500, 1000, 2000};
   logic [1:0] sts[3] = '{2'b01, 2'b11, 2'b00};
   logic [31:0] expq[$];

   assign mot = {motion_block_reset, raw_flag_select, z_sign_select, tilt35_enable, shake_enable,
                 any_motion_enable, motion_latch_enable, tilt_flip_enable};

   amrmc_ctrl #(.CLK_HZ(CLK_HZ), .WDT_CYCLES(WDT)) i_amrmc_ctrl (
      .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .scl_pin(scl_pin),
      .bus_busy(bus_busy), .wdt_timeout(wdt_timeout), .op_state(op_state), .osc_run(osc_run),
      .osc_rate_sel(osc_rate_sel), .sample_tick(sample_tick), .tilt_flip_enable(tilt_flip_enable),
      .motion_latch_enable(motion_latch_enable), .any_motion_enable(any_motion_enable),
      .shake_enable(shake_enable), .tilt35_enable(tilt35_enable), .z_sign_select(z_sign_select),
      .raw_flag_select(raw_flag_select), .motion_block_reset(motion_block_reset));

   amrmc_host i_amrmc_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .scl_pin(scl_pin), .bus_busy(bus_busy));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %0h, seen %0h", what, e, g);
      end
   endtask

   // read results are judged by the monitor when the answer strobe shows
   always @(posedge core_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (expq.size() == 0) chk("spare read answer", 1, 0);
         else chk("read data", expq.pop_front(), {24'h0, reg_rdata});
      end
      if (wdt_timeout === 1'b1) wdt_seen++;
      if (sample_tick === 1'b1) tick_seen++;
   end

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back({24'h0, e});
      i_amrmc_host.rd(a);
   endtask

   task automatic outs(input logic [1:0] st, input logic run);
      @(negedge core_clk);
      chk("op_state", {30'h0, st}, {30'h0, op_state});
      chk("osc_run", {31'h0, run}, {31'h0, osc_run});
   endtask

   task automatic tick_gap(input int e);
      int n;
      n = 0;
      while (sample_tick !== 1'b1 && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (sample_tick !== 1'b1 && n < 5000);
      chk("sample period", e, n);
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // whole run is about 22k cycles; 60k cycles means a hang
   initial begin
      #600000;
      bad_count++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      void'($urandom(89798));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      outs(2'b00, 1'b0);
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      rd(8'h05, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 3; i++) begin
         i_amrmc_host.wr(8'h07, {6'h0, sts[i]});
         outs(sts[i], sts[i] != 2'b00);
         rd(8'h05, {6'h0, sts[i]});
      end
      i_amrmc_host.wr(8'h07, 8'h01);
      i_amrmc_host.wr(8'h07, 8'h32);
      outs(2'b01, 1'b1);
      rd(8'h07, 8'h32);
      $display("test operating states done");
      for (int c = 0; c < 8; c++) begin
         i_amrmc_host.wr(8'h08, c[7:0]);
         @(negedge core_clk);
         chk("osc_rate_sel", c, {29'h0, osc_rate_sel});
         rd(8'h08, 8'h08 | c[7:0]);
         tick_gap(CLK_HZ / output_sample_rate[c]);
      end
      for (int i = 1; i < 3; i++) begin
         i_amrmc_host.wr(8'h07, {6'h0, sts[i]});
         // a tick launched at the write edge may still show once
         repeat (2) @(negedge core_clk);
         tick_seen = 0;
         repeat (300) @(posedge core_clk);
         chk("ticks outside wake", 0, tick_seen);
      end
      $display("test sample rate done");
      i_amrmc_host.wr(8'h07, 8'h11);
      i_amrmc_host.link(40, 1'b1, 0);
      i_amrmc_host.link(4, 1'b1, 24);
      chk("timeouts while toggling or stalled high", 0, wdt_seen);
      i_amrmc_host.link(4, 1'b0, 24);
      chk("low stall timeouts", 1, wdt_seen);
      rd(8'h05, 8'h11);
      rd(8'h05, 8'h01);
      i_amrmc_host.wr(8'h07, 8'h21);
      i_amrmc_host.link(4, 1'b1, 24);
      chk("high stall timeouts", 2, wdt_seen);
      $display("test bus watchdogs done");
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'h18 : 8'($urandom);
         i_amrmc_host.wr(8'h09, v);
         i_amrmc_host.wr(8'h08, 8'h0f);
         @(negedge core_clk);
         chk("motion outputs", {v[7:5], v[4] & v[2], v[3] & v[2], v[2:0]}, mot);
         rd(8'h09, v);
      end
      i_amrmc_host.wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h00);
      rd(8'h09, v);
      $display("test motion and unmapped done");
      repeat (3) @(posedge core_clk);
      chk("pending reads", 0, expq.size());
      conclude();
   end
endmodule
